// ---- logic/rtc_xfer_pkg.sv ----
`default_nettype none
package rtc_xfer_pkg;
   // ---------------------------------------------------------------
   // register word offsets (byte addresses; OFF_OSC_INDEX is a word index)
   // ---------------------------------------------------------------
   localparam logic [5:0] OFF_HOLD0      = 6'h00;
   localparam logic [5:0] OFF_HOLD1      = 6'h04;
   localparam logic [5:0] OFF_HOLD2      = 6'h08;
   localparam logic [5:0] OFF_HOLD3      = 6'h0C;
   localparam logic [5:0] OFF_CTRL       = 6'h10;
   localparam logic [5:0] OFF_OSC        = 6'h14;
   localparam logic [5:0] OFF_IRQ_STAT   = 6'h18;
   localparam logic [5:0] OFF_IRQ_MASK   = 6'h1C;
   localparam logic [5:0] OFF_OSC_INDEX  = 6'h05;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_CAP_BIT   = 0;
   localparam int CTRL_SET_BIT   = 1;
   localparam int CTRL_ALARM_BIT = 2;
   localparam int OSC_GAIN_BIT   = 7;
   localparam int OSC_TYPE_BIT   = 6;
   localparam int OSC_BIAS_BIT   = 5;
   localparam int OSC_VALID_BIT  = 4;
   localparam int IRQ_CAP_BIT    = 0;
   localparam int IRQ_SET_BIT    = 1;
   localparam int IRQ_ALARM_BIT  = 2;
   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] OSC_RESET      = 8'h00;
   localparam logic [2:0] IRQ_RESET      = 3'h0;
   localparam int         XFER_CYCLES    = 2;
endpackage
`default_nettype wire

// ---- logic/rtc_xfer_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface rtc_xfer_if;
   logic        start_cap;
   logic        start_set;
   logic        busy;
   logic        done_cap;
   logic        done_set;
   logic [31:0] hold_val;
   logic [31:0] cap_val;
   modport ctrl (output start_cap, output start_set, output hold_val,
                 input busy, input done_cap, input done_set, input cap_val);
   modport seq  (input start_cap, input start_set, input hold_val,
                 output busy, output done_cap, output done_set, output cap_val);
endinterface
`default_nettype wire

// ---- logic/rtc_xfer_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtc_xfer_seq
   import rtc_xfer_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   rtc_xfer_if.seq          xf,
   input  wire logic [31:0] timer_val_in,
   output logic             load_stb,
   output logic [31:0]      load_val
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_CAP  = 3'b010,
      S_SET  = 3'b100
   } xfer_state_t;

   xfer_state_t state_q;
   logic [1:0]  cnt_q;
   logic        done_cap_q;
   logic        done_set_q;
   logic [31:0] cap_q;
   logic        load_q;

   wire cnt_end = (cnt_q == 2'(XFER_CYCLES - 1));

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q    <= S_IDLE;
         cnt_q      <= 2'h0;
         done_cap_q <= 1'b0;
         done_set_q <= 1'b0;
         cap_q      <= 32'h00000000;
         load_q     <= 1'b0;
      end else begin
         done_cap_q <= 1'b0;
         done_set_q <= 1'b0;
         load_q     <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               cnt_q <= 2'h0;
               if (xf.start_set) begin
                  state_q <= S_SET;
               end else if (xf.start_cap) begin
                  state_q <= S_CAP;
               end
            end
            S_CAP: begin
               cnt_q <= cnt_q + 2'h1;
               if (cnt_end) begin
                  cap_q      <= timer_val_in;
                  done_cap_q <= 1'b1;
                  state_q    <= S_IDLE;
               end
            end
            S_SET: begin
               cnt_q <= cnt_q + 2'h1;
               if (cnt_end) begin
                  load_q     <= 1'b1;
                  done_set_q <= 1'b1;
                  state_q    <= S_IDLE;
               end
            end
         endcase
      end
   end

   assign xf.busy     = (state_q != S_IDLE);
   assign xf.done_cap = done_cap_q;
   assign xf.done_set = done_set_q;
   assign xf.cap_val  = cap_q;
   assign load_stb    = load_q;
   assign load_val    = xf.hold_val;
endmodule // rtc_xfer_seq
`default_nettype wire

// ---- logic/rtc_transfer_and_osc_control.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - writing 1 to capture trigger copies timer to holding; bit clears when done
// - alarm flag stays set; only software write clears it
// - oscillator control bit 7 enables automatic gain control
// - bit 6 selects oscillator type: 0 self-oscillate, 1 crystal
// - bit 5 enables doubled oscillator bias
// - read-only bit 4 shows oscillation amplitude is sufficient
// - bits 3:0 read 0000b, writes ignored
// - oscillator control at internal address 0x05, reset all zero
// - four holding bytes form 32-bit value; set loads timer, capture fills it
module rtc_transfer_and_osc_control
   import rtc_xfer_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [5:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic [31:0] timer_val_in,
   input  wire logic        alarm_match_in,
   input  wire logic        osc_amplitude_valid_in,
   output logic             timer_load_out,
   output logic [31:0]      timer_load_val_out,
   output logic             osc_gain_ctrl_enable_out,
   output logic             osc_type_select_out,
   output logic             bias_double_enable_out,
   output logic             alarm_event_flag_out,
   output logic             irq_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [31:0] timer_holding_regs_q;
   logic        timer_capture_trigger_q;
   logic        timer_set_trigger_q;
   logic        alarm_event_flag_q;
   logic [7:0]  rtc_oscillator_control_q;
   logic        valid_q;
   logic [2:0]  irq_stat_q;
   logic [2:0]  irq_mask_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        load_q;
   logic [31:0] load_val_q;
   logic        irq_q;
   logic        start_cap_q;
   logic        start_set_q;

   rtc_xfer_if xf ();
   logic        seq_load;
   logic [31:0] seq_load_val;

   rtc_xfer_seq u_seq (
      .sys_clk_in   (sys_clk_in),
      .rst_n_in     (rst_n_in),
      .xf           (xf.seq),
      .timer_val_in (timer_val_in),
      .load_stb     (seq_load),
      .load_val     (seq_load_val)
   );

   assign xf.start_cap = start_cap_q;
   assign xf.start_set = start_set_q;
   assign xf.hold_val  = timer_holding_regs_q;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire        req      = (avs_read_in | avs_write_in) & ~ack_q;
   // a write lands at the edge where waitrequest is sampled low
   wire        wr       = avs_write_in & ack_q;
   wire        rd       = avs_read_in & req;
   wire        hit_h0   = (avs_address_in == OFF_HOLD0);
   wire        hit_h1   = (avs_address_in == OFF_HOLD1);
   wire        hit_h2   = (avs_address_in == OFF_HOLD2);
   wire        hit_h3   = (avs_address_in == OFF_HOLD3);
   wire        hit_ctrl = (avs_address_in == OFF_CTRL);
   wire        hit_osc  = (avs_address_in == OFF_OSC);
   wire        hit_stat = (avs_address_in == OFF_IRQ_STAT);
   wire        hit_mask = (avs_address_in == OFF_IRQ_MASK);
   wire        be0      = avs_byteenable_in[0];
   wire [7:0]  wd       = avs_writedata_in[7:0];
   // holding registers locked while a transfer runs
   wire        hold_ok  = ~(timer_capture_trigger_q | timer_set_trigger_q);
   wire        ctrl_wr  = wr & hit_ctrl & be0;
   wire        cap_go   = ctrl_wr & wd[CTRL_CAP_BIT] & hold_ok;
   wire        set_go   = ctrl_wr & wd[CTRL_SET_BIT] & hold_ok & ~wd[CTRL_CAP_BIT];
   wire        alarm_clr = ctrl_wr & ~wd[CTRL_ALARM_BIT];
   wire [7:0]  osc_rd   = {rtc_oscillator_control_q[7:5], valid_q, 4'h0};
   wire [7:0]  ctrl_rd  = {5'h00, alarm_event_flag_q, timer_set_trigger_q, timer_capture_trigger_q};
   wire [2:0]  events   = {alarm_match_in, xf.done_set, xf.done_cap};
   wire [2:0]  stat_clr = (wr & hit_stat & be0) ? avs_writedata_in[2:0] : 3'h0;

   function automatic logic [31:0] put_byte(input logic [31:0] v, input int idx, input logic [7:0] b);
      logic [31:0] r;
      r = v;
      r[idx*8 +: 8] = b;
      return r;
   endfunction

   logic [31:0] rdata_d;
   logic [31:0] hold_d;
   always_comb begin
      rdata_d = 32'h00000000;
      if (hit_h0) rdata_d = {24'h000000, timer_holding_regs_q[7:0]};
      if (hit_h1) rdata_d = {24'h000000, timer_holding_regs_q[15:8]};
      if (hit_h2) rdata_d = {24'h000000, timer_holding_regs_q[23:16]};
      if (hit_h3) rdata_d = {24'h000000, timer_holding_regs_q[31:24]};
      if (hit_ctrl) rdata_d = {24'h000000, ctrl_rd};
      if (hit_osc) rdata_d = {24'h000000, osc_rd};
      if (hit_stat) rdata_d = {29'h00000000, irq_stat_q};
      if (hit_mask) rdata_d = {29'h00000000, irq_mask_q};
      hold_d = timer_holding_regs_q;
      if (xf.done_cap) begin
         hold_d = xf.cap_val;
      end else if (wr & be0 & hold_ok) begin
         if (hit_h0) hold_d = put_byte(hold_d, 0, wd);
         if (hit_h1) hold_d = put_byte(hold_d, 1, wd);
         if (hit_h2) hold_d = put_byte(hold_d, 2, wd);
         if (hit_h3) hold_d = put_byte(hold_d, 3, wd);
      end
   end

   // ---------------------------------------------------------------
   // bus handshake and holding registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_q                <= 1'b0;
         rdata_q              <= 32'h00000000;
         timer_holding_regs_q <= 32'h00000000;
         start_cap_q          <= 1'b0;
         start_set_q          <= 1'b0;
      end else begin
         ack_q                <= req;
         if (rd) rdata_q      <= rdata_d;
         timer_holding_regs_q <= hold_d;
         start_cap_q          <= cap_go;
         start_set_q          <= set_go;
      end
   end

   // ---------------------------------------------------------------
   // triggers and alarm flag
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_capture_trigger_q <= 1'b0;
         timer_set_trigger_q     <= 1'b0;
         alarm_event_flag_q      <= 1'b0;
      end else begin
         if (cap_go) timer_capture_trigger_q <= 1'b1;
         else if (xf.done_cap) timer_capture_trigger_q <= 1'b0;
         if (set_go) timer_set_trigger_q <= 1'b1;
         else if (xf.done_set) timer_set_trigger_q <= 1'b0;
         if (alarm_match_in) alarm_event_flag_q <= 1'b1;
         else if (alarm_clr) alarm_event_flag_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // oscillator control
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rtc_oscillator_control_q <= OSC_RESET;
         valid_q                  <= 1'b0;
      end else begin
         valid_q <= osc_amplitude_valid_in;
         if (wr & hit_osc & be0) begin
            rtc_oscillator_control_q <= {wd[7:5], 5'h00};
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupts and outputs
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_q <= IRQ_RESET;
         irq_mask_q <= IRQ_RESET;
         irq_q      <= 1'b0;
         load_q     <= 1'b0;
         load_val_q <= 32'h00000000;
      end else begin
         irq_stat_q <= (irq_stat_q & ~stat_clr) | events;
         if (wr & hit_mask & be0) irq_mask_q <= avs_writedata_in[2:0];
         irq_q      <= |(irq_stat_q & irq_mask_q);
         load_q     <= seq_load;
         if (seq_load) load_val_q <= seq_load_val;
      end
   end

   assign avs_readdata_out         = rdata_q;
   assign avs_waitrequest_out      = ~ack_q;
   assign timer_load_out           = load_q;
   assign timer_load_val_out       = load_val_q;
   assign osc_gain_ctrl_enable_out = rtc_oscillator_control_q[OSC_GAIN_BIT];
   assign osc_type_select_out      = rtc_oscillator_control_q[OSC_TYPE_BIT];
   assign bias_double_enable_out   = rtc_oscillator_control_q[OSC_BIAS_BIT];
   assign alarm_event_flag_out     = alarm_event_flag_q;
   assign irq_out                  = irq_q;
endmodule // rtc_transfer_and_osc_control
`default_nettype wire

// ---- bench/rtc_xfer_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtc_xfer_props
   import rtc_xfer_pkg::*;
(
   input wire logic        sys_clk_in,
   input wire logic        rst_n_in,
   input wire logic [5:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        alarm_match_in,
   input wire logic        timer_load_out,
   input wire logic        osc_gain_ctrl_enable_out,
   input wire logic        osc_type_select_out,
   input wire logic        bias_double_enable_out,
   input wire logic        alarm_event_flag_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic       acc    = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   wire logic       wr_osc = acc && avs_address_in == OFF_OSC;
   wire logic       wr_ctl = acc && avs_address_in == OFF_CTRL;
   wire logic       set_rq = wr_ctl && avs_writedata_in[1:0] == 2'h2;
   wire logic [2:0] osc    = {osc_gain_ctrl_enable_out, osc_type_select_out, bias_double_enable_out};
   logic [3:0]      age_q;
   // ---------------------------------------------------------------
   // cycles since the last set request, saturating
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) age_q <= 4'hF;
      else if (set_rq) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
   end
   sequence s_set_req; set_rq; endsequence
   sequence s_load; timer_load_out ##1 !timer_load_out; endsequence
   AST_SET_LOAD: assert property (s_set_req |-> ##[1:8] s_load)
      else $error("set request gave no load pulse");
   AST_LOAD_CAUSE: assert property (timer_load_out |-> age_q < 4'h8)
      else $error("load pulse without set request");
   AST_CAP_NO_LOAD: assert property (wr_ctl && avs_writedata_in[0] |=> !timer_load_out [*4])
      else $error("capture request loaded the timer");
   AST_OSC_WRITE: assert property (wr_osc |=> osc == $past(avs_writedata_in[7:5]))
      else $error("oscillator outputs do not follow write");
   AST_OSC_HOLD: assert property (!wr_osc |=> $stable(osc))
      else $error("oscillator outputs changed without write");
   AST_OSC_READ: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == OFF_OSC
      |-> avs_readdata_out[3:0] == 4'h0 && avs_readdata_out[7:5] == osc)
      else $error("oscillator readback wrong");
   AST_OSC_RESET: assert property ($rose(rst_n_in) |-> osc == 3'h0 && !alarm_event_flag_out)
      else $error("state not zero after reset");
   AST_ALARM_SET: assert property (alarm_match_in |-> ##[1:2] alarm_event_flag_out)
      else $error("alarm match did not set flag");
   AST_ALARM_STICKY: assert property (alarm_event_flag_out && !(wr_ctl && !avs_writedata_in[2])
      |=> alarm_event_flag_out)
      else $error("alarm flag cleared by itself");
endmodule // rtc_xfer_props
bind rtc_transfer_and_osc_control rtc_xfer_props u_props (.sys_clk_in, .rst_n_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
   .avs_waitrequest_out, .alarm_match_in, .timer_load_out, .osc_gain_ctrl_enable_out,
   .osc_type_select_out, .bias_double_enable_out, .alarm_event_flag_out);
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   import rtc_xfer_pkg::*;
   logic        clk, rst_n, rd, wr, am, av;
   logic [5:0]  addr;
   logic [31:0] wd, tv, r, loaded;
   logic [3:0]  be;
   logic [7:0]  pat [4] = '{8'hFF, 8'h4F, 8'hA5, 8'h2A};
   wire logic [31:0] rdata, lval;
   wire logic        wreq, load, gain, typ, bias, aflag, irq;
   int          errors, total_checks;
   rtc_transfer_and_osc_control u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .timer_val_in(tv), .alarm_match_in(am),
      .osc_amplitude_valid_in(av), .timer_load_out(load), .timer_load_val_out(lval),
      .osc_gain_ctrl_enable_out(gain), .osc_type_select_out(typ), .bias_double_enable_out(bias),
      .alarm_event_flag_out(aflag), .irq_out(irq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (load === 1'b1) loaded <= lval;
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // one bus cycle, held until waitrequest is sampled low
   // ---------------------------------------------------------------
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) errors++;
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, OFF_CTRL, 32'h0, r);
         n++;
      end while (r[b] !== 1'b0 && n < 20);
      check("trigger", {31'h0, r[b]}, 32'h0);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask
   initial begin
      #200000;
      errors++;
      summarize();
   end
   initial begin
      {rst_n, rd, wr, am, av, addr, wd} = '0;
      be = 4'h1;
      tv = 32'h1234_5678;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, OFF_OSC, 32'h0, r);
      check("osc_reset", r, 32'h0);
      for (int i = 0; i < 4; i++) begin
         av <= !i[0];
         bus(1'b1, OFF_OSC, {24'h0, pat[i]}, r);
         bus(1'b0, OFF_OSC, 32'h0, r);
         check("osc_read", r, {24'h0, pat[i][7:5], !i[0], 4'h0});
         check("osc_pins", {29'h0, gain, typ, bias}, {29'h0, pat[i][7:5]});
      end
      be <= 4'h0;
      bus(1'b1, OFF_OSC, 32'hFF, r);
      be <= 4'h1;
      check("osc_be0", {29'h0, gain, typ, bias}, 32'h1);
      bus(1'b1, OFF_CTRL, 32'h1, r);
      poll(CTRL_CAP_BIT);
      tv <= 32'hCAFE_0000;
      for (int k = 0; k < 4; k++) begin
         bus(1'b0, OFF_HOLD0 + 6'(4 * k), 32'h0, r);
         check("hold_byte", r, {24'h0, 8'(32'h1234_5678 >> (8 * k))});
      end
      bus(1'b0, OFF_IRQ_STAT, 32'h0, r);
      check("stat_cap", r, 32'h1);
      check("irq_masked", {31'h0, irq}, 32'h0);
      bus(1'b1, OFF_IRQ_MASK, 32'h7, r);
      settle();
      check("irq_on", {31'h0, irq}, 32'h1);
      bus(1'b1, OFF_IRQ_STAT, 32'h1, r);
      settle();
      check("irq_off", {31'h0, irq}, 32'h0);
      for (int k = 0; k < 4; k++) bus(1'b1, OFF_HOLD0 + 6'(4 * k), {24'h0, 8'hA1 + 8'(k * 8'h11)}, r);
      bus(1'b1, OFF_CTRL, 32'h2, r);
      poll(CTRL_SET_BIT);
      check("loaded", loaded, 32'hD4C3_B2A1);
      bus(1'b0, OFF_IRQ_STAT, 32'h0, r);
      check("stat_set", r, 32'h2);
      bus(1'b1, OFF_IRQ_STAT, 32'h2, r);
      am <= 1'b1;
      @(posedge clk);
      am <= 1'b0;
      repeat (10) @(posedge clk);
      bus(1'b0, OFF_CTRL, 32'h0, r);
      check("alarm_sticky", {31'h0, r[2]}, 32'h1);
      check("irq_alarm", {31'h0, irq}, 32'h1);
      bus(1'b1, OFF_CTRL, 32'h0, r);
      bus(1'b1, OFF_IRQ_STAT, 32'h4, r);
      settle();
      check("alarm_clear", {30'h0, aflag, irq}, 32'h0);
      bus(1'b1, 6'h20, 32'hFFFF_FFFF, r);
      bus(1'b0, 6'h20, 32'h0, r);
      check("unmapped", r, 32'h0);
      summarize();
   end
endmodule // tb
`default_nettype wire
